// *** lpsr_pkg.sv ***
package lpsr_pkg;
    // ---------------------------------------------------------------
    // command pin encodings {cs_n, ras_n, cas_n, we_n}
    // ---------------------------------------------------------------
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_NOP       = 4'h7;
    localparam logic [3:0] CMD_DESELECT  = 4'hf;
    // ---------------------------------------------------------------
    // bank select and mode register fields
    // ---------------------------------------------------------------
    localparam logic [1:0] BANK_STD_MODE = 2'h0;
    localparam logic [1:0] BANK_STATUS   = 2'h1;
    localparam int         CL_MSB        = 6;
    localparam int         CL_LSB        = 4;
    localparam logic [2:0] CL_CODE_2     = 3'h2;
    localparam logic [2:0] CL_CODE_3     = 3'h3;
    localparam logic [2:0] CL_RESET      = 3'h3;
    // ---------------------------------------------------------------
    // status word fields
    // ---------------------------------------------------------------
    localparam int         DENS_LSB      = 13;
    localparam int         TYPE_BIT      = 12;
    localparam int         WIDTH_BIT     = 11;
    localparam int         MULT_LSB      = 8;
    localparam int         REV_LSB       = 4;
    localparam int         MAKER_LSB     = 0;
    localparam logic [2:0] DENS_128M     = 3'h0;
    localparam logic [2:0] DENS_256M     = 3'h1;
    localparam logic [2:0] DENS_512M     = 3'h2;
    localparam logic       TYPE_LPDDR    = 1'h0;
    localparam logic       WIDTH_X16     = 1'h0;
    localparam logic       WIDTH_X32     = 1'h1;
    localparam logic [2:0] MULT_2X       = 3'h3;
    localparam logic [2:0] MULT_1X       = 3'h4;
    localparam logic [2:0] MULT_QUARTER  = 3'h6;
    localparam logic [3:0] REV_INITIAL   = 4'h0;
    // ---------------------------------------------------------------
    // timing (20 MHz clock)
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 50;
    localparam int SETUP_DELAY_NS     = 100;
    localparam int RECOVERY_DELAY_NS  = 100;
    localparam int SETUP_CYCLES       = (SETUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYCLES    = (RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_LEN          = 2;
    // ---------------------------------------------------------------
    // controller register map
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_WORD    = 4'h8;
    localparam logic [3:0] REG_REFI    = 4'hc;
    localparam int         CTRL_START  = 0;
    localparam int         CTRL_CL_LSB = 1;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_DONE   = 1;
endpackage : lpsr_pkg

// *** lpsr_if.sv ***
`timescale 1ns/100ps
interface lpsr_if;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank;
    logic [12:0] addr;
    logic [31:0] dq_from_dev;
    logic [31:0] dq_oe_dev;
    logic        dq_valid;

    modport dev (
        input  cs_n, ras_n, cas_n, we_n, bank, addr,
        output dq_from_dev, dq_oe_dev, dq_valid
    );
    modport ctl (
        output cs_n, ras_n, cas_n, we_n, bank, addr,
        input  dq_from_dev, dq_oe_dev, dq_valid
    );
endinterface : lpsr_if

// *** lpsr_dev.sv ***
`timescale 1ns/100ps
// What this block does
// - controller starts only from its own idle state
// - load-mode with bank 01, address zero
// - controller waits setup delay, NOP only
// - controller then issues READ
// - controller waits recovery delay, NOP only
// - status returned as two-beat burst
// - word on first beat, second ignored
// - data after programmed read latency
// - status word field layout
// - refresh multiplier from temperature sensor
// - controller scales base refresh interval
// - revision starts at initial code
// - reserved bits read zero
// - read latency 2 or 3, bits 6..4
// - READ encoding cs low cas low
// - load-mode encoding all strobes low
module lpsr_dev #(
    parameter logic [2:0] DENSITY  = lpsr_pkg::DENS_512M,
    parameter logic       WIDTH    = lpsr_pkg::WIDTH_X32,
    parameter logic [3:0] REVISION = lpsr_pkg::REV_INITIAL,
    // arbitrary maker value
    parameter logic [3:0] MAKER    = 4'h5
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // temperature sensor multiplier code
    input  wire logic [2:0] temp_mult,
    // memory command side
    lpsr_if.dev             bus
);
    logic [3:0]  cmd;
    logic [2:0]  cl_q;
    logic        pend_q;
    logic [1:0]  pipe_q;
    logic [31:0] word;
    logic [31:0] dq_q;
    logic        oe_q;
    logic        first_q;

    assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};

    always_comb begin
        word = 32'h0000_0000;
        word[lpsr_pkg::DENS_LSB +: 3]  = DENSITY;
        word[lpsr_pkg::TYPE_BIT]       = lpsr_pkg::TYPE_LPDDR;
        word[lpsr_pkg::WIDTH_BIT]      = WIDTH;
        word[lpsr_pkg::MULT_LSB +: 3]  = temp_mult;
        word[lpsr_pkg::REV_LSB +: 4]   = REVISION;
        word[lpsr_pkg::MAKER_LSB +: 4] = MAKER;
    end

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    // standard mode load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cl_q <= lpsr_pkg::CL_RESET;
        end else if (cmd == lpsr_pkg::CMD_LOAD_MODE && bus.bank == lpsr_pkg::BANK_STD_MODE
                     && (bus.addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB] == lpsr_pkg::CL_CODE_2
                     || bus.addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB] == lpsr_pkg::CL_CODE_3)) begin
            cl_q <= bus.addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= 1'b0;
        end else if (cmd == lpsr_pkg::CMD_LOAD_MODE && bus.bank == lpsr_pkg::BANK_STATUS
                     && bus.addr == 13'h0000) begin
            pend_q <= 1'b1;
        end else if (cmd == lpsr_pkg::CMD_READ) begin
            pend_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // latency pipe
    // ---------------------------------------------------------------
    // programmed latency
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pipe_q <= 2'h0;
        end else begin
            pipe_q <= {pipe_q[0], (cmd == lpsr_pkg::CMD_READ) && pend_q};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_q    <= 1'b0;
            first_q <= 1'b0;
            dq_q    <= 32'h0000_0000;
        end else begin
            if ((cl_q == lpsr_pkg::CL_CODE_2) ? pipe_q[0] : pipe_q[1]) begin
                oe_q    <= 1'b1;
                first_q <= 1'b1;
                dq_q    <= word;
            end else if (first_q) begin
                first_q <= 1'b0;
                // second beat carries no meaning
                dq_q    <= 32'h0000_0000;
            end else begin
                oe_q    <= 1'b0;
            end
        end
    end

    assign bus.dq_from_dev = dq_q;
    assign bus.dq_oe_dev   = {32{oe_q}};
    assign bus.dq_valid    = first_q;
endmodule : lpsr_dev

// *** lpsr_ctl.sv ***
`timescale 1ns/100ps
module lpsr_ctl #(
    parameter logic [15:0] BASE_REFI = 16'h0100
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // memory side
    lpsr_if.ctl              bus
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_READ  = 3'h2,
        ST_WAIT  = 3'h3,
        ST_REC   = 3'h4
    } lpsr_state_e;

    lpsr_state_e state_q;
    logic [3:0]  cnt_q;
    logic [2:0]  cl_q;
    logic        done_q;
    logic [31:0] word_q;
    logic [17:0] refi_q;
    logic [3:0]  cmd_q;
    logic [1:0]  bank_q;
    logic [31:0] dq_s1_q;
    logic [31:0] dq_s2_q;
    logic        vld_s1_q;
    logic        vld_s2_q;
    logic        start;

    assign start = reg_wr && reg_addr == lpsr_pkg::REG_CTRL
                   && reg_wdata[lpsr_pkg::CTRL_START] && state_q == ST_IDLE;

    // pins from the device pass two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dq_s1_q  <= 32'h0000_0000;
            dq_s2_q  <= 32'h0000_0000;
            vld_s1_q <= 1'b0;
            vld_s2_q <= 1'b0;
        end else begin
            dq_s1_q  <= bus.dq_from_dev;
            dq_s2_q  <= dq_s1_q;
            vld_s1_q <= bus.dq_valid;
            vld_s2_q <= vld_s1_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cl_q <= lpsr_pkg::CL_RESET;
        end else if (reg_wr && reg_addr == lpsr_pkg::REG_CTRL) begin
            cl_q <= reg_wdata[lpsr_pkg::CTRL_CL_LSB +: 3];
        end
    end

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            cmd_q   <= lpsr_pkg::CMD_DESELECT;
            bank_q  <= 2'h0;
        end else begin
            cmd_q <= lpsr_pkg::CMD_NOP;
            unique case (state_q)
                ST_IDLE: begin
                    cmd_q <= lpsr_pkg::CMD_DESELECT;
                    if (start) begin
                        cmd_q   <= lpsr_pkg::CMD_LOAD_MODE;
                        bank_q  <= lpsr_pkg::BANK_STATUS;
                        cnt_q   <= 4'(lpsr_pkg::SETUP_CYCLES);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_q == 4'h1) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    cmd_q   <= lpsr_pkg::CMD_READ;
                    bank_q  <= 2'h0;
                    cnt_q   <= 4'(lpsr_pkg::RECOVERY_CYCLES);
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                    if (vld_s2_q) begin
                        state_q <= ST_REC;
                    end
                end
                ST_REC: begin
                    if (cnt_q <= 4'h1) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_q <= 32'h0000_0000;
            refi_q <= 18'h00000;
        end else if (state_q == ST_WAIT && vld_s2_q) begin
            word_q <= dq_s2_q;
            unique case (dq_s2_q[lpsr_pkg::MULT_LSB +: 3])
                lpsr_pkg::MULT_2X:      refi_q <= {1'b0, BASE_REFI, 1'b0};
                lpsr_pkg::MULT_1X:      refi_q <= {2'h0, BASE_REFI};
                lpsr_pkg::MULT_QUARTER: refi_q <= {4'h0, BASE_REFI[15:2]};
                default:                refi_q <= {2'h0, BASE_REFI};
            endcase
        end
    end

    // done sticky: set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else if (state_q == ST_WAIT && vld_s2_q) begin
            done_q <= 1'b1;
        end else if (reg_wr && reg_addr == lpsr_pkg::REG_STATUS
                     && reg_wdata[lpsr_pkg::STAT_DONE]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                lpsr_pkg::REG_CTRL:   reg_rdata <= {28'h0, cl_q, 1'b0};
                lpsr_pkg::REG_STATUS: reg_rdata <= {30'h0, done_q, state_q != ST_IDLE};
                lpsr_pkg::REG_WORD:   reg_rdata <= word_q;
                lpsr_pkg::REG_REFI:   reg_rdata <= {14'h0, refi_q};
                default:              reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_q;
    assign bus.bank = bank_q;
    assign bus.addr = 13'h0000;
endmodule : lpsr_ctl

// *** lpsr_chk.sv ***
`timescale 1ns/100ps
module lpsr_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // command pins
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  bank,
    input wire logic [12:0] addr,
    // device data
    input wire logic [31:0] dq_from_dev,
    input wire logic [31:0] dq_oe_dev,
    input wire logic        dq_valid
);
    logic [3:0] cmd;
    logic [2:0] cl_q;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cl_q <= lpsr_pkg::CL_RESET;
        end else if (cmd == lpsr_pkg::CMD_LOAD_MODE && bank == lpsr_pkg::BANK_STD_MODE
                     && (addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB] == lpsr_pkg::CL_CODE_2
                     || addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB] == lpsr_pkg::CL_CODE_3)) begin
            cl_q <= addr[lpsr_pkg::CL_MSB:lpsr_pkg::CL_LSB];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ---------------------------------------------------------------
    // command sequences
    // ---------------------------------------------------------------
    sequence s_idle;
        cs_n || cmd == lpsr_pkg::CMD_NOP;
    endsequence
    sequence s_read;
        cmd == lpsr_pkg::CMD_READ;
    endsequence
    sequence s_load;
        cmd == lpsr_pkg::CMD_LOAD_MODE;
    endsequence
    a_status_request: assert property (s_load |-> bank == lpsr_pkg::BANK_STATUS && addr == 13'h0)
        else $error("load-mode without status bank or zero address");
    a_setup_wait: assert property (s_load |=> s_idle [*2])
        else $error("command inside status setup delay");
    a_read_follows: assert property (s_load |=> s_idle ##[1:6] s_read)
        else $error("no read after status request");
    a_recovery_wait: assert property (s_read |=> s_idle [*2])
        else $error("command inside status recovery delay");
    a_read_latency: assert property (dq_valid |-> ((cl_q == lpsr_pkg::CL_CODE_2) ?
        $past(cmd, 2) == lpsr_pkg::CMD_READ : $past(cmd, 3) == lpsr_pkg::CMD_READ))
        else $error("status beat not at read latency");
    a_read_answer: assert property (s_read |-> ##2 (dq_valid || cl_q != lpsr_pkg::CL_CODE_2)
        ##1 (dq_valid || cl_q == lpsr_pkg::CL_CODE_2))
        else $error("status read gave no beat");
    a_single_beat: assert property (dq_valid |=> !dq_valid && dq_oe_dev == '1)
        else $error("burst is not two beats");
    a_oe_window: assert property (dq_oe_dev != 32'h0 |-> dq_valid || $past(dq_valid))
        else $error("data lines driven outside burst");
    a_word_lines: assert property (dq_valid |-> dq_oe_dev == '1)
        else $error("not all data lines driven on first beat");
    a_reserved_zero: assert property (dq_valid |-> dq_from_dev[31:16] == 16'h0)
        else $error("reserved status bits not zero");
endmodule : lpsr_chk

// *** lpsr_status_read_tb.sv ***
`timescale 1ns/100ps
module lpsr_status_read_tb;
    localparam logic [15:0] BASE_REFI = 16'h0100;
    // arbitrary maker value
    localparam logic [3:0]  MAKER     = 4'ha;
    typedef struct packed {logic [2:0] mult; logic [31:0] refi;} lpsr_row_s;
    logic        clk       = 1'b0;
    logic        nrst      = 1'b0;
    logic [2:0]  temp_mult = 3'h4;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic [31:0] vword;
    int          mismatches = 0;
    int          n_tests    = 0;
    int          ncyc       = 0;
    int          vcount     = 0;
    int          vwhen      = 0;
    lpsr_row_s   rows [4]   = '{'{3'h3, 32'h200}, '{3'h4, 32'h100}, '{3'h6, 32'h40},
                                '{3'h7, 32'h100}};
    lpsr_if lpsr_if_i ();
    lpsr_if lpsr_if_i2 ();
    lpsr_dev #(.DENSITY(lpsr_pkg::DENS_256M), .WIDTH(lpsr_pkg::WIDTH_X16), .MAKER(MAKER))
        lpsr_dev_i (.clk(clk), .nrst(nrst), .temp_mult(temp_mult), .bus(lpsr_if_i));
    lpsr_dev #(.DENSITY(lpsr_pkg::DENS_256M), .WIDTH(lpsr_pkg::WIDTH_X16), .MAKER(MAKER))
        lpsr_dev_i2 (.clk(clk), .nrst(nrst), .temp_mult(temp_mult), .bus(lpsr_if_i2));
    lpsr_ctl #(.BASE_REFI(BASE_REFI)) lpsr_ctl_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus(lpsr_if_i));
    lpsr_chk lpsr_chk_i (.clk(clk), .nrst(nrst), .cs_n(lpsr_if_i.cs_n),
        .ras_n(lpsr_if_i.ras_n), .cas_n(lpsr_if_i.cas_n), .we_n(lpsr_if_i.we_n),
        .bank(lpsr_if_i.bank), .addr(lpsr_if_i.addr), .dq_from_dev(lpsr_if_i.dq_from_dev),
        .dq_oe_dev(lpsr_if_i.dq_oe_dev), .dq_valid(lpsr_if_i.dq_valid));
    initial forever #25 clk = ~clk;
    // negedge sampling keeps the count clear of the launch edge
    always @(negedge clk) begin
        ncyc = ncyc + 1;
        if (lpsr_if_i2.dq_valid === 1'b1) begin
            vcount = vcount + 1;
            vwhen = ncyc;
            vword = lpsr_if_i2.dq_from_dev;
        end
    end
    function automatic logic [31:0] exp_word(input logic [2:0] m);
        return {16'h0, lpsr_pkg::DENS_256M, lpsr_pkg::TYPE_LPDDR, lpsr_pkg::WIDTH_X16, m,
                lpsr_pkg::REV_INITIAL, MAKER};
    endfunction : exp_word
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic cmd2(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        {lpsr_if_i2.cs_n, lpsr_if_i2.ras_n, lpsr_if_i2.cas_n, lpsr_if_i2.we_n} <= c;
        lpsr_if_i2.bank <= b;
        lpsr_if_i2.addr <= a;
        @(posedge clk);
    endtask : cmd2
    task automatic wait_done();
        for (int i = 0; i < 40; i++) begin
            rd(lpsr_pkg::REG_STATUS, rv);
            if (rv[lpsr_pkg::STAT_DONE] === 1'b1)
                return;
        end
        mismatches = mismatches + 1;
        test_done();
    endtask : wait_done
    initial begin
        {lpsr_if_i2.cs_n, lpsr_if_i2.ras_n, lpsr_if_i2.cas_n, lpsr_if_i2.we_n} = 4'hf;
        lpsr_if_i2.bank = 2'h0;
        lpsr_if_i2.addr = 13'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(lpsr_pkg::REG_STATUS, rv);
        check(rv, 32'h0);
        rd(4'h2, rv);
        check(rv, 32'h0);
        foreach (rows[i]) begin
            temp_mult <= rows[i].mult;
            // second start lands while busy and must be ignored
            wr(lpsr_pkg::REG_CTRL, 32'h7);
            wr(lpsr_pkg::REG_CTRL, 32'h7);
            wait_done();
            rd(lpsr_pkg::REG_STATUS, rv);
            check(rv, 32'h2);
            rd(lpsr_pkg::REG_WORD, rv);
            check(rv, exp_word(rows[i].mult));
            rd(lpsr_pkg::REG_REFI, rv);
            check(rv, rows[i].refi);
            wr(lpsr_pkg::REG_STATUS, 32'h2);
            rd(lpsr_pkg::REG_STATUS, rv);
            check(rv, 32'h0);
        end
        rd(lpsr_pkg::REG_CTRL, rv);
        check(rv, {28'h0, lpsr_pkg::CL_CODE_3, 1'b0});
        wr(lpsr_pkg::REG_CTRL, 32'h7);
        nrst <= 1'b0;
        #1 check({31'h0, lpsr_if_i.cs_n}, 32'h1);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(lpsr_pkg::REG_STATUS, rv);
        check(rv, 32'h0);
        cmd2(lpsr_pkg::CMD_READ, 2'h0, 13'h0);
        vcount = 0;
        repeat (8) cmd2(lpsr_pkg::CMD_NOP, 2'h0, 13'h0);
        check(32'(vcount), 32'h0);
        for (int cl = 2; cl <= 3; cl++) begin
            cmd2(lpsr_pkg::CMD_LOAD_MODE, lpsr_pkg::BANK_STD_MODE, 13'(cl << lpsr_pkg::CL_LSB));
            repeat (2) cmd2(lpsr_pkg::CMD_NOP, 2'h0, 13'h0);
            cmd2(lpsr_pkg::CMD_LOAD_MODE, lpsr_pkg::BANK_STATUS, 13'h0);
            repeat (2) cmd2(lpsr_pkg::CMD_NOP, 2'h0, 13'h0);
            cmd2(lpsr_pkg::CMD_READ, 2'h0, 13'h0);
            ncyc = 0;
            vcount = 0;
            repeat (8) cmd2(lpsr_pkg::CMD_NOP, 2'h0, 13'h0);
            check(32'(vcount), 32'h1);
            check(32'(vwhen), 32'(cl));
            check(vword, exp_word(temp_mult));
        end
        test_done();
    end
endmodule : lpsr_status_read_tb
